// File: src/mts_map.svh
// Register map, field positions, reset values and timing figures of the
// measurement trigger sequencer.
// Assumes a 40 MHz ref_clk and a 32-bit classic Wishbone register bus.
`ifndef MTS_MAP_SVH
`define MTS_MAP_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define MTS_ADR_CTRL       8'h00
`define MTS_ADR_SMPCNT     8'h04
`define MTS_ADR_PRECNT     8'h08
`define MTS_ADR_DLYMAN     8'h0C
`define MTS_ADR_LEVEL      8'h10
`define MTS_ADR_CMD        8'h14
`define MTS_ADR_STATUS     8'h18

// ****************************************
// Control word fields and reset values
// ****************************************
`define MTS_CTRL_W         13
`define MTS_CTRL_RST       13'h0000
`define MTS_CMD_INIT       0
`define MTS_CMD_BUSTRIG    1
`define MTS_CMD_CONF       2
`define MTS_CMD_MEAS       3
`define MTS_CMD_ABORT      4
`define MTS_SMPCNT_RST     1
`define MTS_PRECNT_RST     0
`define MTS_DLYMAN_RST     32'h0000_0000
`define MTS_LEVEL_RST      0

// ****************************************
// Timing
// ****************************************
`define MTS_CLK_PERIOD_NS  25
`define MTS_TICK_NS        1000
`define MTS_TICK_CYC       (`MTS_TICK_NS / `MTS_CLK_PERIOD_NS)
`define MTS_DLY_MAX_S      3600
`define MTS_DLY_MAX_US     (64'(`MTS_DLY_MAX_S) * 64'd1000000)
`define MTS_CMP_PULSE_NS   2000
`define MTS_CMP_PULSE_CYC  ((`MTS_CMP_PULSE_NS + `MTS_CLK_PERIOD_NS - 1) / `MTS_CLK_PERIOD_NS)

`endif

// File: src/mts_pkg.sv
// Types shared by the measurement trigger sequencer files.
// Assumes mts_map.svh supplies the numeric layout.
package mts_pkg;

   typedef enum logic [2:0] {
      MODE_AUTO   = 3'b000,
      MODE_SINGLE = 3'b001,
      MODE_HOLD   = 3'b010,
      MODE_IMM    = 3'b011,
      MODE_EXT    = 3'b100,
      MODE_BUS    = 3'b101,
      MODE_INT    = 3'b110
   } mts_mode_e;

   typedef enum logic [2:0] {
      FN_DCV   = 3'b000,
      FN_ACV   = 3'b001,
      FN_DCI   = 3'b010,
      FN_ACI   = 3'b011,
      FN_RES2  = 3'b100,
      FN_RES4  = 3'b101,
      FN_CONT  = 3'b110,
      FN_DIODE = 3'b111
   } mts_func_e;

   typedef enum logic [1:0] {
      DLY_AUTO   = 2'b00,
      DLY_ZERO   = 2'b01,
      DLY_MANUAL = 2'b10
   } mts_dly_e;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_WAIT  = 3'b001,
      ST_DELAY = 3'b010,
      ST_ISSUE = 3'b011,
      ST_BUSY  = 3'b100
   } mts_state_e;

   // Control word, bit 0 is the LSB of mode
   typedef struct packed {
      logic       intSlopeRise;
      mts_dly_e   delaySel;
      mts_func_e  func;
      logic       beepEn;
      logic       completePulsePolarity;
      logic       extSlopeRise;
      logic       remote;
      mts_mode_e  mode;
   } mts_ctrl_s;

endpackage

// File: src/mts_tick_div.sv
// Time-base divider: one-cycle enable every DIV clocks.
// Assumes a single free-running clock with synchronous active-low reset.
`include "mts_map.svh"

module mts_tick_div #(
   parameter int DIV = `MTS_TICK_CYC
) (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rstn,
   // Tick
   output logic      tick
);

   logic [15:0] cnt_r;
   wire         wrap = (cnt_r == 16'(DIV - 1));

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         cnt_r <= 16'h0000;
         tick  <= 1'b0;
      end else begin
         cnt_r <= wrap ? 16'h0000 : cnt_r + 16'h0001;
         tick  <= wrap;
      end
   end

endmodule

// File: src/mts_trigger_seq.sv
// Measurement trigger sequencer: trigger source selection, sample count,
// pre-trigger, trigger delay, reading hold and measurement-complete output.
// Assumes a reading engine that answers each sampleReq with one sampleDone
// pulse, all inputs synchronous to ref_clk.
`include "mts_map.svh"

module mts_trigger_seq #(
   parameter int CNT_W       = 20,
   parameter int MAX_SAMPLES = 50000,
   parameter int LVL_W       = 16,
   parameter int TICK_DIV    = `MTS_TICK_CYC
) (
   // Clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rstn,
   // Wishbone slave
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [7:0]       wb_adr_i,
   input  wire logic [3:0]       wb_sel_i,
   input  wire logic [31:0]      wb_dat_i,
   output logic      [31:0]      wb_dat_o,
   output logic                  wb_ack_o,
   // Front panel
   input  wire logic             panelTrigKey,
   input  wire logic             panelRangeSel,
   // External trigger handshake
   input  wire logic             extTrigIn,
   output logic                  measurementCompleteOutput,
   // Reading engine
   output logic                  sampleReq,
   output logic                  pretrigPhase,
   input  wire logic             sampleDone,
   input  wire logic             sampleStable,
   input  wire logic [LVL_W-1:0] levelIn,
   input  wire logic             levelValid,
   input  wire logic [31:0]      autoDelayUs,
   // Indicators
   output logic                  trigWaiting,
   output logic                  holdActive,
   output logic                  holdUpdate,
   output logic                  beepPulse
);

   // ****************************************
   // Register bus
   // ****************************************
   mts_pkg::mts_ctrl_s ctrl_r;
   mts_pkg::mts_ctrl_s ctrlNxt;
   mts_pkg::mts_ctrl_s ctrlWr;
   mts_pkg::mts_state_e state_r;
   mts_pkg::mts_state_e stateNxt;
   logic [CNT_W-1:0] sampleCount_r;
   logic [CNT_W-1:0] pretriggerSampleCount_r;
   logic [31:0]      delayManual_r;
   logic [LVL_W-1:0] level_r;
   logic [CNT_W-1:0] samplesLeft_r;
   logic [31:0]      delayCnt_r;
   logic             extPending_r;
   logic             extPrev_r;
   logic             prevAbove_r;
   logic             preBusy_r;
   logic [7:0]       cmpCnt_r;

   wire        wbReq   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire        wbWr    = wbReq & wb_we_i;
   wire [31:0] selMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire        hitCtrl = (wb_adr_i == `MTS_ADR_CTRL);
   wire        hitSmp  = (wb_adr_i == `MTS_ADR_SMPCNT);
   wire        hitPre  = (wb_adr_i == `MTS_ADR_PRECNT);
   wire        hitDly  = (wb_adr_i == `MTS_ADR_DLYMAN);
   wire        hitLvl  = (wb_adr_i == `MTS_ADR_LEVEL);
   wire        hitCmd  = (wb_adr_i == `MTS_ADR_CMD);
   wire        hitStat = (wb_adr_i == `MTS_ADR_STATUS);

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat, input logic [31:0] m);
      merge = (old & ~m) | (dat & m);
   endfunction

   wire [31:0] ctrlWord = merge({19'h0, ctrl_r}, wb_dat_i, selMask);
   wire [31:0] smpWord  = merge(32'(sampleCount_r), wb_dat_i, selMask);
   wire [31:0] preWord  = merge(32'(pretriggerSampleCount_r), wb_dat_i, selMask);
   wire [31:0] dlyWord  = merge(delayManual_r, wb_dat_i, selMask);
   wire [31:0] lvlWord  = merge(32'(level_r), wb_dat_i, selMask);
   wire [31:0] cmdWord  = wb_dat_i & selMask;

   wire wrCtrl    = wbWr & hitCtrl;
   wire wrSmp     = wbWr & hitSmp;
   wire wrPre     = wbWr & hitPre;
   wire wrDly     = wbWr & hitDly;
   wire cmdInit   = wbWr & hitCmd & cmdWord[`MTS_CMD_INIT];
   wire cmdBus    = wbWr & hitCmd & cmdWord[`MTS_CMD_BUSTRIG];
   wire cmdConf   = wbWr & hitCmd & cmdWord[`MTS_CMD_CONF];
   wire cmdMeas   = wbWr & hitCmd & cmdWord[`MTS_CMD_MEAS];
   wire cmdAbort  = wbWr & hitCmd & cmdWord[`MTS_CMD_ABORT];

   // Count of zero is taken as one, excess clamps to the maximum
   wire [CNT_W-1:0] smpClamp = (smpWord == 32'h0) ? CNT_W'(1) :
                               (smpWord > 32'(MAX_SAMPLES)) ? CNT_W'(MAX_SAMPLES) : smpWord[CNT_W-1:0];
   wire [31:0]      dlyClamp = (64'(dlyWord) > `MTS_DLY_MAX_US) ? 32'(`MTS_DLY_MAX_US) : dlyWord;

   assign ctrlWr = mts_pkg::mts_ctrl_s'(ctrlWord[`MTS_CTRL_W-1:0]);

   wire remoteEnter = wrCtrl & ctrlWr.remote & ~ctrl_r.remote;
   wire funcChange  = wrCtrl & (ctrlWr.func != ctrl_r.func);

   always_comb begin
      ctrlNxt = ctrl_r;
      if (wrCtrl) begin
         ctrlNxt = ctrlWr;
      end
      if (remoteEnter || cmdConf || cmdMeas) begin
         ctrlNxt.mode = mts_pkg::MODE_IMM;
      end
      if (cmdMeas) begin
         ctrlNxt.delaySel = mts_pkg::DLY_AUTO;
      end
      if ((ctrl_r.mode == mts_pkg::MODE_HOLD) && (funcChange || remoteEnter || panelRangeSel)) begin
         ctrlNxt.mode = remoteEnter ? mts_pkg::MODE_IMM : mts_pkg::MODE_AUTO;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         ctrl_r                  <= mts_pkg::mts_ctrl_s'(`MTS_CTRL_RST);
         sampleCount_r           <= CNT_W'(`MTS_SMPCNT_RST);
         pretriggerSampleCount_r <= CNT_W'(`MTS_PRECNT_RST);
         delayManual_r           <= `MTS_DLYMAN_RST;
         level_r                 <= LVL_W'(`MTS_LEVEL_RST);
      end else begin
         ctrl_r <= ctrlNxt;
         if (wrSmp) sampleCount_r <= smpClamp;
         if (wrPre) pretriggerSampleCount_r <= preWord[CNT_W-1:0];
         if (wrDly) delayManual_r <= dlyClamp;
         if (wbWr && hitLvl) level_r <= lvlWord[LVL_W-1:0];
      end
   end

   wire [31:0] statWord = {20'h0, extPending_r, preBusy_r, holdActive, trigWaiting, 5'h0, state_r};
   wire [31:0] rdData   = hitCtrl ? {19'h0, ctrl_r} :
                          hitSmp  ? 32'(sampleCount_r) :
                          hitPre  ? 32'(pretriggerSampleCount_r) :
                          hitDly  ? delayManual_r :
                          hitLvl  ? 32'(level_r) :
                          hitStat ? statWord : 32'h0000_0000;

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wbReq;
         wb_dat_o <= (wbReq && !wb_we_i) ? rdData : 32'h0000_0000;
      end
   end

   // ****************************************
   // Trigger sources
   // ****************************************
   wire tick;

   mts_tick_div #(
      .DIV     (TICK_DIV)
   ) u_tick (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .tick    (tick)
   );

   mts_pkg::mts_mode_e mode;
   assign mode = ctrl_r.mode;

   wire contDiode = (ctrl_r.func == mts_pkg::FN_CONT) || (ctrl_r.func == mts_pkg::FN_DIODE);
   wire levelFunc = !contDiode;
   wire extEvt    = ctrl_r.extSlopeRise ? (extTrigIn & ~extPrev_r) : (~extTrigIn & extPrev_r);
   wire curAbove  = $signed(levelIn) >= $signed(level_r);
   wire crossEvt  = levelValid & levelFunc &
                    (ctrl_r.intSlopeRise ? (curAbove & ~prevAbove_r) : (~curAbove & prevAbove_r));
   wire extSrc    = (mode == mts_pkg::MODE_SINGLE) || (mode == mts_pkg::MODE_EXT);
   wire freeRun   = (mode == mts_pkg::MODE_AUTO) || (mode == mts_pkg::MODE_HOLD);
   wire localArm  = freeRun || (mode == mts_pkg::MODE_SINGLE);
   wire modeChg   = (ctrlNxt.mode != ctrl_r.mode);
   wire inReading = (state_r == mts_pkg::ST_DELAY) || (state_r == mts_pkg::ST_ISSUE) ||
                    (state_r == mts_pkg::ST_BUSY);

   // Pending external trigger; a new edge wins over its own consumption
   wire extConsume = (state_r == mts_pkg::ST_WAIT) && extSrc && extPending_r && !preBusy_r;
   wire extStore   = extEvt && extSrc && inReading;

   logic trigEvt;
   always_comb begin
      case (mode)
         mts_pkg::MODE_AUTO:   trigEvt = 1'b1;
         mts_pkg::MODE_HOLD:   trigEvt = 1'b1;
         mts_pkg::MODE_SINGLE: trigEvt = panelTrigKey | extEvt | extPending_r;
         mts_pkg::MODE_IMM:    trigEvt = 1'b1;
         mts_pkg::MODE_EXT:    trigEvt = extEvt | extPending_r;
         mts_pkg::MODE_BUS:    trigEvt = cmdBus | panelTrigKey;
         mts_pkg::MODE_INT:    trigEvt = crossEvt;
         default:              trigEvt = 1'b0;
      endcase
   end

   // ****************************************
   // Counts and delay selection
   // ****************************************
   wire             preOk    = (sampleCount_r > CNT_W'(1)) && (pretriggerSampleCount_r < sampleCount_r) &&
                               (pretriggerSampleCount_r != CNT_W'(0)) && !contDiode && !freeRun;
   wire [CNT_W-1:0] preEff   = preOk ? pretriggerSampleCount_r : CNT_W'(0);
   wire [CNT_W-1:0] postCnt  = sampleCount_r - preEff;
   wire [31:0]      delayEff = (contDiode || ctrl_r.delaySel == mts_pkg::DLY_ZERO) ? 32'h0000_0000 :
                               (ctrl_r.delaySel == mts_pkg::DLY_MANUAL) ? delayManual_r :
                               autoDelayUs;
   wire             fire     = (state_r == mts_pkg::ST_WAIT) && trigEvt && !preBusy_r;
   wire             lastSmp  = !freeRun && (samplesLeft_r <= CNT_W'(1));

   // ****************************************
   // Sequencer
   // ****************************************
   always_comb begin
      stateNxt = state_r;
      case (state_r)
         mts_pkg::ST_IDLE: begin
            if (localArm || cmdInit || cmdMeas) stateNxt = mts_pkg::ST_WAIT;
         end
         mts_pkg::ST_WAIT: begin
            if (fire) stateNxt = mts_pkg::ST_DELAY;
         end
         mts_pkg::ST_DELAY: begin
            if (delayCnt_r == 32'h0000_0000) stateNxt = mts_pkg::ST_ISSUE;
         end
         mts_pkg::ST_ISSUE: begin
            stateNxt = mts_pkg::ST_BUSY;
         end
         mts_pkg::ST_BUSY: begin
            if (sampleDone) begin
               if (!lastSmp) stateNxt = mts_pkg::ST_ISSUE;
               else if (localArm || mode == mts_pkg::MODE_EXT) stateNxt = mts_pkg::ST_WAIT;
               else stateNxt = mts_pkg::ST_IDLE;
            end
         end
         default: stateNxt = mts_pkg::ST_IDLE;
      endcase
      // Changing count, delay or source abandons the sequence until re-armed
      if (cmdAbort || wrSmp || wrPre || wrDly || modeChg) stateNxt = mts_pkg::ST_IDLE;
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         state_r <= mts_pkg::ST_IDLE;
      end else begin
         state_r <= stateNxt;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         samplesLeft_r <= CNT_W'(0);
         delayCnt_r    <= 32'h0000_0000;
      end else if (fire) begin
         samplesLeft_r <= postCnt;
         delayCnt_r    <= delayEff;
      end else begin
         if (state_r == mts_pkg::ST_DELAY && tick && delayCnt_r != 32'h0000_0000) begin
            delayCnt_r <= delayCnt_r - 32'h0000_0001;
         end
         if (state_r == mts_pkg::ST_BUSY && sampleDone && !lastSmp && !freeRun) begin
            samplesLeft_r <= samplesLeft_r - CNT_W'(1);
         end
      end
   end

   // Edge history and the one-deep external trigger store
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         extPrev_r    <= 1'b0;
         prevAbove_r  <= 1'b0;
         extPending_r <= 1'b0;
      end else begin
         extPrev_r <= extTrigIn;
         if (levelValid) prevAbove_r <= curAbove;
         if (extStore) extPending_r <= 1'b1;
         else if (extConsume || !extSrc || modeChg) extPending_r <= 1'b0;
      end
   end

   // ****************************************
   // Engine requests and pre-trigger sampling
   // ****************************************
   // Pre-trigger readings run while waiting; a trigger event during the one in flight is dropped, not held
   wire preGo = (state_r == mts_pkg::ST_WAIT) && preOk && !preBusy_r && !fire;

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         sampleReq    <= 1'b0;
         preBusy_r    <= 1'b0;
         pretrigPhase <= 1'b0;
      end else begin
         sampleReq    <= (state_r == mts_pkg::ST_ISSUE) || preGo;
         pretrigPhase <= (state_r == mts_pkg::ST_WAIT) && preOk;
         if (preGo) preBusy_r <= 1'b1;
         else if (sampleDone) preBusy_r <= 1'b0;
      end
   end

   // ****************************************
   // Indicators, hold and complete pulse
   // ****************************************
   wire measDone = sampleDone && (state_r == mts_pkg::ST_BUSY || preBusy_r);
   wire holdHit  = sampleDone && (state_r == mts_pkg::ST_BUSY) && (mode == mts_pkg::MODE_HOLD) && sampleStable;

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         trigWaiting <= 1'b0;
         holdActive  <= 1'b0;
         holdUpdate  <= 1'b0;
         beepPulse   <= 1'b0;
      end else begin
         trigWaiting <= (stateNxt == mts_pkg::ST_WAIT) && !freeRun && (mode != mts_pkg::MODE_IMM);
         holdActive  <= (ctrlNxt.mode == mts_pkg::MODE_HOLD);
         holdUpdate  <= holdHit;
         beepPulse   <= holdHit && ctrl_r.beepEn;
      end
   end

   // Pulse stretched so that slow external switch gear can see it
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         cmpCnt_r                  <= 8'h00;
         measurementCompleteOutput <= 1'b1;
      end else begin
         if (measDone) cmpCnt_r <= 8'(`MTS_CMP_PULSE_CYC);
         else if (cmpCnt_r != 8'h00) cmpCnt_r <= cmpCnt_r - 8'h01;
         measurementCompleteOutput <= ((measDone || cmpCnt_r > 8'h01) == ctrl_r.completePulsePolarity);
      end
   end

endmodule

// File: sim/mts_trigger_seq_props.sv
// Port-level checks of the trigger sequencer.
// Assumes one ref_clk domain and synchronous active-low rstn.
module mts_trigger_seq_props (
   // Clock and reset
   input wire logic        ref_clk,
   input wire logic        rstn,
   // Register bus
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   input wire logic [31:0] wb_dat_o,
   // Engine and panel
   input wire logic        sampleReq,
   input wire logic        sampleDone,
   input wire logic        panelRangeSel,
   input wire logic        measurementCompleteOutput,
   input wire logic        trigWaiting,
   input wire logic        holdActive,
   input wire logic        holdUpdate,
   input wire logic        beepPulse
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   a_ack_pulse:
      assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   a_ack_answer:
      assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
   a_rdata_idle:
      assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
   a_req_pulse:
      assert property (sampleReq |=> !sampleReq) else $error("request held");
   a_req_gap:
      assert property (sampleDone |=> !sampleReq) else $error("request right after done");
   a_hold_nowait:
      assert property (holdActive |-> !trigWaiting) else $error("waiting in hold");
   a_beep_update:
      assert property (beepPulse |-> holdUpdate) else $error("beep without update");
   a_range_cancel:
      assert property (panelRangeSel && holdActive |-> ##[1:3] !holdActive) else $error("hold kept");
   a_reset_state:
      assert property (disable iff (1'b0) !rstn |=> measurementCompleteOutput && !trigWaiting
                       && !holdActive && !sampleReq) else $error("bad reset state");

   c_update: cover property (holdUpdate);
   c_trig: cover property ($fell(trigWaiting));
   c_bus: cover property (wb_ack_o && wb_cyc_i);
endmodule

bind mts_trigger_seq mts_trigger_seq_props u_props (
   .ref_clk(ref_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .sampleReq(sampleReq), .sampleDone(sampleDone),
   .panelRangeSel(panelRangeSel), .measurementCompleteOutput(measurementCompleteOutput),
   .trigWaiting(trigWaiting), .holdActive(holdActive), .holdUpdate(holdUpdate), .beepPulse(beepPulse)
);

// File: sim/mts_engine_model.sv
// Reading engine stand-in: one sampleDone for each sampleReq.
// Assumes the sequencer keeps one reading outstanding.
module mts_engine_model (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rstn,
   // Behaviour
   input  wire logic slow,
   input  wire logic stableIn,
   // Handshake
   input  wire logic sampleReq,
   output logic      sampleDone = 1'b0,
   output logic      sampleStable = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   int latency_r = 0;

   // Stable flag only means something with done, so it toggles otherwise
   always @(posedge ref_clk) begin
      sampleDone <= 1'b0;
      sampleStable <= ~sampleStable;
      if (!rstn)
         latency_r <= 0;
      else if (sampleReq)
         latency_r <= slow ? 2 + $urandom % 6 : 1;
      else if (latency_r == 1) begin
         latency_r <= 0;
         sampleDone <= 1'b1;
         sampleStable <= stableIn;
      end else if (latency_r > 1)
         latency_r <= latency_r - 1;
   end
endmodule

// File: sim/mts_trigger_seq_bench.sv
// Self-checking bench of the trigger sequencer with an engine model.
// Assumes TICK_DIV of 2, so one delay tick is two ref_clk cycles.
`include "mts_map.svh"

module mts_trigger_seq_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic               ref_clk = 1'b0, rstn = 1'b0, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
   logic               key = 1'b0, rangeSel = 1'b0, ext = 1'b1, lvlValid = 1'b0, slow = 1'b0;
   logic               stableIn = 1'b1, wbAck, mco, sReq, preT, sDone, sStable;
   logic               waiting, holdAct, holdUpd, beep;
   logic [7:0]         wbAdr = 8'h00;
   logic [15:0]        lvl = 16'h0;
   logic [31:0]        wbDatW = 32'h0, wbDatR, autoDly = 32'h4, rd;
   logic [7:0]         adrs [5] = '{`MTS_ADR_CTRL, `MTS_ADR_SMPCNT, `MTS_ADR_PRECNT, `MTS_ADR_DLYMAN, 8'h1C};
   logic [31:0]        exps [5] = '{32'h0, 32'h1, 32'h0, 32'h0, 32'h0};
   int                 mismatches = 0, nCompared = 0, nReq = 0, nUpd = 0, nBeep = 0, n, base;
   mts_pkg::mts_ctrl_s c;

   always #12.5 ref_clk = ~ref_clk;

   always @(posedge ref_clk) begin
      nReq <= nReq + int'(sReq === 1'b1);
      nUpd <= nUpd + int'(holdUpd === 1'b1);
      nBeep <= nBeep + int'(beep === 1'b1);
   end

   mts_trigger_seq #(.TICK_DIV(2)) uut (
      .ref_clk(ref_clk), .rstn(rstn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
      .wb_adr_i(wbAdr), .wb_sel_i(4'hF), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck),
      .panelTrigKey(key), .panelRangeSel(rangeSel), .extTrigIn(ext), .measurementCompleteOutput(mco),
      .sampleReq(sReq), .pretrigPhase(preT), .sampleDone(sDone), .sampleStable(sStable),
      .levelIn(lvl), .levelValid(lvlValid), .autoDelayUs(autoDly), .trigWaiting(waiting),
      .holdActive(holdAct), .holdUpdate(holdUpd), .beepPulse(beep)
   );

   mts_engine_model u_engine (
      .ref_clk(ref_clk), .rstn(rstn), .slow(slow), .stableIn(stableIn),
      .sampleReq(sReq), .sampleDone(sDone), .sampleStable(sStable)
   );

   // ****************************************
   // Tasks
   // ****************************************
   task automatic summarize();
      $display("compared %0d, mismatches %0d", nCompared, mismatches);
      if (mismatches == 0 && nCompared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      nCompared++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge ref_clk);
   endtask

   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
      int i;
      @(posedge ref_clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= adr;
      wbDatW <= d;
      for (i = 0; i < 20; i++) begin
         @(posedge ref_clk);
         if (wbAck === 1'b1)
            break;
      end
      rd = wbDatR;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      if (i == 20) begin
         mismatches++;
         summarize();
      end
   endtask

   task automatic ctl(input mts_pkg::mts_mode_e m, input logic rem, input mts_pkg::mts_func_e f,
                      input mts_pkg::mts_dly_e d, input logic bp);
      c = '0;
      c.mode = m;
      c.remote = rem;
      c.func = f;
      c.delaySel = d;
      c.beepEn = bp;
      c.intSlopeRise = 1'b1;
      wb(1'b1, `MTS_ADR_CTRL, 32'(c));
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      void'($urandom(32'h9b0b28dd));
      tick(5);
      rstn <= 1'b1;
      chk(32'(mco), 32'h1);
      foreach (adrs[i]) begin
         wb(1'b0, adrs[i], 32'h0);
         chk(rd, exps[i]);
      end
      base = nReq;
      tick(60);
      chk(32'(nReq - base > 3), 32'h1);
      $display("done: reset and auto");

      for (int k = 0; k < 3; k++) begin
         n = 2 + $urandom % 4;
         slow <= k[0];
         wb(1'b1, `MTS_ADR_SMPCNT, 32'(n));
         ctl(mts_pkg::MODE_IMM, 1'b1, mts_pkg::FN_DCV, mts_pkg::DLY_ZERO, 1'b0);
         base = nReq;
         wb(1'b1, `MTS_ADR_CMD, 32'h1 << `MTS_CMD_INIT);
         tick(150);
         chk(32'(nReq - base), 32'(n));
         chk(32'(waiting), 32'h0);
      end
      $display("done: immediate");

      ctl(mts_pkg::MODE_SINGLE, 1'b1, mts_pkg::FN_DCV, mts_pkg::DLY_ZERO, 1'b0);
      base = nReq;
      tick(30);
      chk(32'(waiting), 32'h1);
      chk(32'(preT), 32'h0);
      key <= 1'b1;
      tick(1);
      key <= 1'b0;
      tick(2);
      chk(32'(waiting), 32'h0);
      key <= 1'b1;
      ext <= 1'b0;
      tick(1);
      key <= 1'b0;
      ext <= 1'b1;
      tick(200);
      chk(32'(nReq - base), 32'(2 * n));
      $display("done: single");

      ctl(mts_pkg::MODE_BUS, 1'b1, mts_pkg::FN_DCV, mts_pkg::DLY_ZERO, 1'b0);
      wb(1'b1, `MTS_ADR_CMD, 32'h1 << `MTS_CMD_INIT);
      base = nReq;
      tick(20);
      chk(32'(nReq - base), 32'h0);
      wb(1'b1, `MTS_ADR_CMD, 32'h1 << `MTS_CMD_BUSTRIG);
      tick(150);
      chk(32'(nReq - base), 32'(n));
      $display("done: bus");

      wb(1'b1, `MTS_ADR_LEVEL, 32'd100);
      for (int f = 0; f < 8; f += 6) begin
         ctl(mts_pkg::MODE_INT, 1'b1, mts_pkg::mts_func_e'(f[2:0]), mts_pkg::DLY_ZERO, 1'b0);
         wb(1'b1, `MTS_ADR_CMD, 32'h1 << `MTS_CMD_INIT);
         base = nReq;
         lvlValid <= 1'b1;
         repeat (20) begin
            lvl <= 16'($urandom % 100);
            @(posedge ref_clk);
         end
         lvl <= 16'd200;
         tick(150);
         lvlValid <= 1'b0;
         chk(32'(nReq - base), f == 0 ? 32'(n) : 32'h0);
      end
      $display("done: level");

      ctl(mts_pkg::MODE_HOLD, 1'b0, mts_pkg::FN_DCV, mts_pkg::DLY_ZERO, 1'b1);
      tick(100);
      chk(32'(holdAct), 32'h1);
      chk(32'(nUpd > 0 && nUpd == nBeep), 32'h1);
      stableIn <= 1'b0;
      tick(3);
      base = nUpd;
      tick(60);
      chk(32'(nUpd - base), 32'h0);
      rangeSel <= 1'b1;
      tick(1);
      rangeSel <= 1'b0;
      tick(3);
      chk(32'(holdAct), 32'h0);
      ctl(mts_pkg::MODE_HOLD, 1'b0, mts_pkg::FN_DCV, mts_pkg::DLY_ZERO, 1'b1);
      ctl(mts_pkg::MODE_HOLD, 1'b1, mts_pkg::FN_DCV, mts_pkg::DLY_ZERO, 1'b1);
      tick(3);
      chk(32'(holdAct), 32'h0);
      $display("done: hold");

      for (int i = 0; i < 2; i++) begin
         ctl(mts_pkg::MODE_BUS, 1'b1, mts_pkg::FN_DCV, mts_pkg::DLY_MANUAL, 1'b0);
         wb(1'b1, `MTS_ADR_CMD, 32'h1 << (`MTS_CMD_CONF + i));
         wb(1'b0, `MTS_ADR_CTRL, 32'h0);
         chk(32'(rd[2:0]), 32'(mts_pkg::MODE_IMM));
         if (i == 1)
            chk(32'(rd[11:10]), 32'(mts_pkg::DLY_AUTO));
      end
      $display("done: configure and measure");

      tick(150);
      wb(1'b1, `MTS_ADR_SMPCNT, 32'h0);
      wb(1'b0, `MTS_ADR_SMPCNT, 32'h0);
      chk(rd, 32'h1);
      wb(1'b1, `MTS_ADR_DLYMAN, 32'd20);
      ctl(mts_pkg::MODE_IMM, 1'b1, mts_pkg::FN_DCV, mts_pkg::DLY_MANUAL, 1'b0);
      base = nReq;
      wb(1'b1, `MTS_ADR_CMD, 32'h1 << `MTS_CMD_INIT);
      tick(30);
      chk(32'(nReq - base), 32'h0);
      tick(30);
      chk(32'(nReq - base), 32'h1);
      tick(3);
      chk(32'(mco), 32'h0);
      tick(90);
      chk(32'(mco), 32'h1);
      ctl(mts_pkg::MODE_IMM, 1'b1, mts_pkg::FN_CONT, mts_pkg::DLY_MANUAL, 1'b0);
      base = nReq;
      wb(1'b1, `MTS_ADR_CMD, 32'h1 << `MTS_CMD_INIT);
      tick(12);
      chk(32'(nReq - base), 32'h1);
      autoDly <= 32'd15;
      ctl(mts_pkg::MODE_IMM, 1'b1, mts_pkg::FN_DCV, mts_pkg::DLY_AUTO, 1'b0);
      base = nReq;
      wb(1'b1, `MTS_ADR_CMD, 32'h1 << `MTS_CMD_INIT);
      tick(20);
      chk(32'(nReq - base), 32'h0);
      tick(30);
      chk(32'(nReq - base), 32'h1);
      $display("done: delay");
      summarize();
   end
endmodule
